// ### hw/drv_ctrl.sv
// Purpose: diagnostic, protection and output control of a six output load driver
// Assumes: raw analog comparator levels synchronous to aclk; AXI4-Lite master
// Notes: aresetn stands for the internal power-on reset and logic undervoltage
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`include "drv_ctrl_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module drv_ctrl
  import drv_ctrl_pkg::*;
#(
  parameter int unsigned FILT_OPEN_CYCLES = `FILT_OPEN_CYC,
  parameter int unsigned FILT_SHORT_CYCLES = `FILT_SHORT_CYC,
  parameter int unsigned RCV_BASE_CYCLES = `RCV_BASE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic modulation_input_a,
  input wire logic shared_monitor_modulation_pin_in,
  output logic shared_monitor_modulation_pin_out,
  output logic shared_monitor_modulation_pin_oe,
  input wire logic [5:0] raw_open_load,
  input wire logic [5:0] raw_over_current,
  input wire logic raw_supply_ov,
  input wire logic raw_supply_uv,
  input wire logic raw_temp_warn,
  input wire logic raw_thermal_sd,
  output logic [5:0] high_drive,
  output logic [5:0] low_drive,
  output logic [5:0] out_enable,
  output logic [1:0] monitor_select,
  output logic monitor_blank,
  output logic charge_pump_en
);

  // ************************************************************
  // register bus
  // ************************************************************
  logic [31:0] ctrl0_reg;
  logic [31:0] ctrl1_reg;
  diag_s diag_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [3:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // byte lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  wire do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire wr_ctrl0 = do_write && (awaddr_reg == `CTRL0_OFS);
  wire wr_ctrl1 = do_write && (awaddr_reg == `CTRL1_OFS);
  wire wr_ok = wr_ctrl0 || wr_ctrl1 || (awaddr_reg == `STAT0_OFS) ||
               (awaddr_reg == `STAT1_OFS);
  wire [31:0] ctrl0_new = merge(ctrl0_reg, wdata_reg, wstrb_reg);
  wire standby_req = wr_ctrl0 && !ctrl0_new[`CTRL_ENABLE_BIT]; // R3
  wire status_clr = wr_ctrl0 && ctrl0_new[`CTRL_RESET_BIT]; // R22
  wire active = ctrl0_reg[`CTRL_ENABLE_BIT];

  // address and data taken in either order, response follows both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 4'h0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ready registered, dropped while a word is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // status words; bit 0 is the no-error bit
  wire any_fault = |diag_reg;
  wire [31:0] stat0_word = {23'h00_0000, diag_reg.supply_ov, diag_reg.supply_uv,
                            diag_reg.over_current, !any_fault};
  wire [31:0] stat1_word = {16'h0000, diag_reg.temp_warn, diag_reg.thermal_sd,
                            diag_reg.open_load, 7'h00, !any_fault};
  wire [3:0] ra = {s_axi_araddr[3:2], 2'b00};
  wire rd_hit = (ra == `CTRL0_OFS) || (ra == `CTRL1_OFS) || (ra == `STAT0_OFS) ||
                (ra == `STAT1_OFS);
  wire [31:0] rd_word = (ra == `CTRL0_OFS) ? ctrl0_reg :
                        (ra == `CTRL1_OFS) ? ctrl1_reg :
                        (ra == `STAT0_OFS) ? stat0_word :
                        (ra == `STAT1_OFS) ? stat1_word : 32'h0000_0000;

  // read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // control registers; standby clears all latched data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_reg <= `CTRL0_RESET; // R1
      ctrl1_reg <= `CTRL1_RESET;
    end else if (standby_req) begin
      ctrl0_reg <= `CTRL0_RESET; // R3
      ctrl1_reg <= `CTRL1_RESET;
    end else begin
      if (wr_ctrl0) begin
        ctrl0_reg <= ctrl0_new & ~(32'h1 << `CTRL_RESET_BIT);
      end
      if (wr_ctrl1) begin
        ctrl1_reg <= merge(ctrl1_reg, wdata_reg, wstrb_reg);
      end
    end
  end

  // ************************************************************
  // diagnostic filters
  // ************************************************************
  logic [15:0] raw_vec;
  logic [15:0] filt_vec;
  logic [5:0] drive_on;
  assign raw_vec = {raw_open_load & drive_on, raw_over_current, raw_supply_ov,
                    raw_supply_uv, raw_temp_warn, raw_thermal_sd}; // R13

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gen_filt
      localparam int unsigned LIM = (g >= 10) ? FILT_OPEN_CYCLES : FILT_SHORT_CYCLES; // R4
      logic [17:0] cnt_reg;
      // counter restarts whenever the raw level drops
      always_ff @(posedge aclk) begin
        if (!aresetn || !raw_vec[g]) begin
          cnt_reg <= 18'h0_0000; // R24
        end else if (cnt_reg < LIM[17:0]) begin
          cnt_reg <= cnt_reg + 18'h0_0001;
        end
      end
      assign filt_vec[g] = (cnt_reg == LIM[17:0]);
    end
  endgenerate

  // sticky flags; set wins over clear, temperature clear needs cool down
  wire [15:0] set_vec = filt_vec & {16{active}};
  wire [15:0] cur_vec = diag_reg;
  wire [15:0] hold_temp = {14'h0000, raw_temp_warn, raw_thermal_sd}; // R11
  always_ff @(posedge aclk) begin
    if (!aresetn || standby_req) begin
      diag_reg <= '0; // R2
    end else if (status_clr) begin
      diag_reg <= set_vec | (cur_vec & hold_temp); // R22
    end else begin
      diag_reg <= cur_vec | set_vec; // R10
    end
  end

  // ************************************************************
  // output enables and recovery
  // ************************************************************
  wire uvov = diag_reg.supply_ov || diag_reg.supply_uv;
  logic [13:0] sup_cnt_reg;
  logic sup_ok_reg;
  wire sup_raw_bad = raw_supply_ov || raw_supply_uv;
  // supply good for 32 us before auto restart
  always_ff @(posedge aclk) begin
    if (!aresetn || sup_raw_bad) begin
      sup_cnt_reg <= 14'h0000;
      sup_ok_reg <= 1'b0;
    end else if (sup_cnt_reg < FILT_SHORT_CYCLES[13:0]) begin
      sup_cnt_reg <= sup_cnt_reg + 14'h0001;
    end else begin
      sup_ok_reg <= 1'b1; // R7
    end
  end
  wire sup_block = ctrl0_reg[`CTRL_UVOV_DIS_BIT] ? uvov : (uvov && !sup_ok_reg); // R8
  wire global_off = !active || diag_reg.thermal_sd || sup_block; // R6 R12

  // per output over-current recovery timers
  logic [5:0] oc_off;
  wire [5:0] rcv_en = ctrl1_reg[11:6];
  wire [19:0] rcv_lim = RCV_BASE_CYCLES[19:0] *
                        {18'h0_0000, ctrl1_reg[`CTRL1_RCV_TIME_LO +: 2]} + RCV_BASE_CYCLES[19:0];
  generate
    for (g = 0; g < 6; g++) begin : gen_rcv
      logic [19:0] rc_reg;
      logic off_reg;
      // recovery timer re-enables after programmed time
      always_ff @(posedge aclk) begin
        if (!aresetn || !diag_reg.over_current[g]) begin
          off_reg <= 1'b0;
          rc_reg <= 20'h0_0000;
        end else if (filt_vec[4 + g]) begin
          off_reg <= 1'b1; // R14
          rc_reg <= 20'h0_0000;
        end else if (rcv_en[g] && rc_reg >= rcv_lim) begin
          off_reg <= 1'b0; // R21
        end else begin
          off_reg <= off_reg | !rcv_en[g]; // R15
          rc_reg <= rc_reg + 20'h0_0001;
        end
      end
      assign oc_off[g] = off_reg || (diag_reg.over_current[g] && !rcv_en[g]);
    end
  endgenerate

  // ************************************************************
  // modulation and half bridge dead time
  // ************************************************************
  wire [5:0] mod_src = {modulation_input_a, shared_monitor_modulation_pin_in,
                        {4{modulation_input_a}}}; // R19
  wire [5:0] on_ctl = ctrl0_reg[6:1];
  wire [5:0] mod_en = ctrl1_reg[5:0];
  wire [5:0] want = (on_ctl & (~mod_en | mod_src)) & ~oc_off & {6{!global_off}}; // R18 R5
  wire [2:0] hb_low = ctrl0_reg[9:7];
  assign drive_on = want;

  logic [5:0] hi_next;
  logic [5:0] lo_next;
  logic [5:0] en_next;
  generate
    for (g = 0; g < 3; g++) begin : gen_hb
      hb_state_e st_reg;
      logic side_reg;
      logic [7:0] dt_reg;
      wire tgt_side = want[g] && !hb_low[g];
      wire tgt_on = want[g];
      // opposite side waits out the cross-current time
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          st_reg <= hb_off;
          side_reg <= 1'b0;
          dt_reg <= 8'h00;
        end else begin
          unique case (st_reg)
            hb_off: begin
              dt_reg <= 8'h00;
              if (tgt_on) begin
                st_reg <= hb_dead; // R20
                side_reg <= tgt_side;
              end
            end
            hb_dead: begin
              dt_reg <= dt_reg + 8'h01;
              if (!tgt_on) begin
                st_reg <= hb_off;
              end else if (dt_reg >= 8'(`XPROT_CYC)) begin
                st_reg <= hb_on; // R20
              end
            end
            hb_on: begin
              dt_reg <= 8'h00;
              if (!tgt_on || tgt_side != side_reg) begin
                st_reg <= hb_off;
              end
            end
            default: st_reg <= hb_off;
          endcase
        end
      end
      assign hi_next[g] = en_next[g] && side_reg;
      assign lo_next[g] = en_next[g] && !side_reg;
      assign en_next[g] = (st_reg == hb_on) && tgt_on && (tgt_side == side_reg); // R20
    end
  endgenerate
  assign hi_next[5:3] = want[5:3];
  assign lo_next[5:3] = 3'b000;
  assign en_next[5:3] = want[5:3];

  // ************************************************************
  // current monitor and outputs
  // ************************************************************
  wire [1:0] sel = ctrl0_reg[`CTRL_SEL_LO +: 2]; // R17
  wire sel_on = (sel == 2'd0) ? hi_next[0] : hi_next[2 + sel]; // R23
  logic sel_on_d_reg;
  logic [13:0] blank_cnt_reg;
  // blank after switch on of the selected driver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_on_d_reg <= 1'b0;
      blank_cnt_reg <= 14'h0000;
    end else begin
      sel_on_d_reg <= sel_on;
      if (sel_on && !sel_on_d_reg) begin
        blank_cnt_reg <= FILT_SHORT_CYCLES[13:0]; // R16
      end else if (blank_cnt_reg != 14'h0000) begin
        blank_cnt_reg <= blank_cnt_reg - 14'h0001;
      end
    end
  end

  // all outputs registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_drive <= 6'h00; // R2
      low_drive <= 6'h00;
      out_enable <= 6'h00;
      monitor_select <= 2'b00;
      monitor_blank <= 1'b1;
      charge_pump_en <= 1'b0;
      shared_monitor_modulation_pin_out <= 1'b0;
      shared_monitor_modulation_pin_oe <= 1'b0;
    end else begin
      high_drive <= hi_next;
      low_drive <= lo_next;
      out_enable <= en_next; // R6
      monitor_select <= sel;
      monitor_blank <= !sel_on || (blank_cnt_reg != 14'h0000) ||
                       (sel_on && !sel_on_d_reg);
      charge_pump_en <= active; // R9
      shared_monitor_modulation_pin_out <= 1'b0;
      shared_monitor_modulation_pin_oe <= active && !mod_en[4];
    end
  end
endmodule
`default_nettype wire

// ### hw/drv_ctrl_defines.svh
// Purpose: constants for the load driver control block
// Assumes: aclk at 125 MHz, AXI4-Lite word registers
// Notes: offsets are byte addresses
//
// Overview of operation
// [R1] internal power-on reset initializes all logic state, no reset pin
// [R2] logic supply low tri-states every output and clears status
// [R3] control bit 23 zero enters standby clearing all latched data
// [R4] diagnostics must persist 32 us, open-load 1 ms, before flag sets
// [R5] open-load and temperature warning flags never change outputs
// [R6] supply over or undervoltage tri-states all six outputs
// [R7] supply recovery restores outputs after at least 32 us
// [R8] recovery disable bit 20 keeps outputs off until status cleared
// [R9] charge pump enabled in active mode, off in standby
// [R10] over-temperature 32 us sets shutdown and switches off all outputs
// [R11] temperature flags latched until cleared and below threshold
// [R12] cleared shutdown bit reactivates outputs to programmed states
// [R13] open-load monitored on activated outputs, 1 ms filter
// [R14] over-current 32 us sets flag and switches that driver off
// [R15] without recovery bit, driver stays off until over-current flag cleared
// [R16] current monitor blanked at least 32 us after selected driver on
// [R17] bits 18 and 19 select the current monitor source
// [R18] modulation enable ANDs external input with control bit
// [R19] high_side_b uses shared pin, others use modulation_input_a
// [R20] half bridge waits cross-current time before opposite side turns on
// [R21] recovery bit re-enables output after programmable recovery time
// [R22] reset bit 22 clears both status registers at frame end
// [R23] select codes 0..3 route half_bridge_a, high_side_a, b, c
// [R24] filters are counters restarted when raw condition drops
`ifndef DRV_CTRL_DEFINES_SVH
`define DRV_CTRL_DEFINES_SVH
`define CTRL0_OFS 4'h0
`define CTRL1_OFS 4'h4
`define STAT0_OFS 4'h8
`define STAT1_OFS 4'hC
`define CTRL_ENABLE_BIT 23
`define CTRL_RESET_BIT 22
`define CTRL_UVOV_DIS_BIT 20
`define CTRL_SEL_LO 18
`define CTRL1_RCV_TIME_LO 12
`define CLK_MHZ 125
`define FILT_SHORT_US 32
`define FILT_OPEN_US 1000
`define FILT_SHORT_CYC (`FILT_SHORT_US * `CLK_MHZ)
`define FILT_OPEN_CYC (`FILT_OPEN_US * `CLK_MHZ)
`define XPROT_NS 1000
`define XPROT_CYC ((`XPROT_NS * `CLK_MHZ + 999) / 1000)
`define RCV_BASE_NS 50000
`define RCV_BASE_CYC ((`RCV_BASE_NS * `CLK_MHZ) / 1000)
`define CTRL0_RESET 32'h0000_0000
`define CTRL1_RESET 32'h0000_0000
`endif

// ### hw/drv_ctrl_pkg.sv
// Purpose: types for the load driver control block
// Assumes: nothing
// Notes: six outputs, three half bridges
package drv_ctrl_pkg;
  typedef logic [5:0] out_vec_t;
  typedef enum logic [2:0] {
    hb_off = 3'b001,
    hb_dead = 3'b010,
    hb_on = 3'b100
  } hb_state_e;
  typedef struct packed {
    logic [5:0] open_load;
    logic [5:0] over_current;
    logic supply_ov;
    logic supply_uv;
    logic temp_warn;
    logic thermal_sd;
  } diag_s;
endpackage

// ### tb/axi_host.sv
// Purpose: AXI4-Lite host model driving the control registers
// Assumes: one write and one read at most in flight
// Notes: released payload shows inverted values, never the last one
`timescale 1ns/1ps
`default_nettype none
module axi_host (
  input wire logic aclk,
  output logic [3:0] s_axi_awaddr = 4'h0,
  output logic s_axi_awvalid = 1'b0,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata = 32'h0000_0000,
  output logic [3:0] s_axi_wstrb = 4'hF,
  output logic s_axi_wvalid = 1'b0,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready = 1'b0,
  output logic [3:0] s_axi_araddr = 4'h0,
  output logic s_axi_arvalid = 1'b0,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready = 1'b0
);
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // read: address held until taken, data taken with rvalid
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/drv_ctrl_asserts.sv
// Purpose: port level checks of drv_ctrl
// Assumes: one clock domain, synchronous active-low reset
// Notes: fault counters follow the raw comparator levels
`timescale 1ns/1ps
`default_nettype none
module drv_ctrl_asserts
  import drv_ctrl_pkg::*;
#(
  parameter int unsigned FILT_SHORT_CYCLES = 4000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] raw_over_current,
  input wire logic raw_supply_ov,
  input wire logic raw_thermal_sd,
  input wire logic [5:0] high_drive,
  input wire logic [5:0] low_drive,
  input wire logic [5:0] out_enable,
  input wire logic [1:0] monitor_select,
  input wire logic monitor_blank,
  input wire logic charge_pump_en
);
  // ****************
  // fault duration counters
  // ****************
  localparam int unsigned LIM = FILT_SHORT_CYCLES + 6;
  int unsigned ov_cnt;
  int unsigned sd_cnt;
  int unsigned oc_cnt;
  // consecutive raw fault cycles, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ov_cnt <= 0;
      sd_cnt <= 0;
      oc_cnt <= 0;
    end else begin
      ov_cnt <= raw_supply_ov ? ((ov_cnt < LIM) ? ov_cnt + 1 : LIM) : 0;
      sd_cnt <= raw_thermal_sd ? ((sd_cnt < LIM) ? sd_cnt + 1 : LIM) : 0;
      oc_cnt <= raw_over_current[5] ? ((oc_cnt < LIM) ? oc_cnt + 1 : LIM) : 0;
    end
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // low side of bridge a stays off for 8 cycles after its high side drops
  sequence s_low_a_off;
    !low_drive[0] [*8];
  endsequence
  // blanking window after high_side_a turns on
  sequence s_blank_run;
    monitor_blank [*4];
  endsequence
  AST_STANDBY_OFF: assert property (!charge_pump_en |-> out_enable == 6'h00)
    else $error("output enabled in standby");
  AST_PUMP_BY_WRITE: assert property ($changed(charge_pump_en) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("charge pump changed without a write");
  AST_SEL_BY_WRITE: assert property ($changed(monitor_select) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("monitor select changed without a write");
  AST_OV_OFF: assert property (ov_cnt == LIM |-> out_enable == 6'h00)
    else $error("outputs on during supply overvoltage");
  AST_SD_OFF: assert property (sd_cnt == LIM |-> out_enable == 6'h00)
    else $error("outputs on during thermal shutdown");
  AST_OC_OFF: assert property (oc_cnt == LIM |-> !out_enable[5])
    else $error("driver on during over-current");
  AST_HB_EXCL: assert property ((high_drive[2:0] & low_drive[2:0]) == 3'h0)
    else $error("both sides of a half bridge on");
  AST_HB_DEAD: assert property ($fell(high_drive[0]) |-> s_low_a_off)
    else $error("low side on within dead time");
  AST_BLANK: assert property ($rose(out_enable[3]) && monitor_select == 2'h1 |=> s_blank_run)
    else $error("monitor not blanked after turn on");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule
bind drv_ctrl drv_ctrl_asserts #(.FILT_SHORT_CYCLES(FILT_SHORT_CYCLES)) drv_ctrl_asserts_i (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .raw_over_current, .raw_supply_ov, .raw_thermal_sd, .high_drive, .low_drive,
  .out_enable, .monitor_select, .monitor_blank, .charge_pump_en);
`default_nettype wire

// ### tb/tb_drv_ctrl.sv
// Purpose: self-checking bench for drv_ctrl
// Assumes: short filter parameters, AXI host model
// Notes: expectations come from an integer model of the control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_drv_ctrl
  import drv_ctrl_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic mod_a = 1'b0, pwm_b = 1'b0, pin_b_in, pin_b_out, pin_b_oe;
  logic [5:0] raw_open_load = 6'h00, raw_over_current = 6'h00;
  logic raw_supply_ov = 1'b0, raw_supply_uv = 1'b0, raw_temp_warn = 1'b0, raw_thermal_sd = 1'b0;
  logic [5:0] high_drive, low_drive, out_enable;
  logic [1:0] monitor_select;
  logic monitor_blank, charge_pump_en;
  int err_count = 0, n_compared = 0, cyc = 0;
  int ctrl0_m = 0, st0_m = 0, st1_m = 0, oc_m = 0, off_m = 0;
  // clock, shared pin level and run limit
  always #4 aclk = ~aclk;
  assign pin_b_in = pin_b_oe ? pin_b_out : pwm_b;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  axi_host axi_host_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  drv_ctrl #(.FILT_OPEN_CYCLES(40), .FILT_SHORT_CYCLES(8), .RCV_BASE_CYCLES(20)) drv_ctrl_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .modulation_input_a(mod_a), .shared_monitor_modulation_pin_in(pin_b_in),
    .shared_monitor_modulation_pin_out(pin_b_out), .shared_monitor_modulation_pin_oe(pin_b_oe),
    .raw_open_load, .raw_over_current, .raw_supply_ov, .raw_supply_uv, .raw_temp_warn,
    .raw_thermal_sd, .high_drive, .low_drive, .out_enable, .monitor_select, .monitor_blank,
    .charge_pump_en);
  // ****************
  // model and helpers
  // ****************
  function automatic logic [5:0] exp_oe();
    return (ctrl0_m[23] && !off_m) ? 6'(ctrl0_m >> 1) & ~6'(oc_m) : 6'h00;
  endfunction
  function automatic logic [31:0] st_exp(input int s);
    return 32'(s) | 32'((st0_m | st1_m) == 0);
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    axi_host_i.wr(a, v, r);
    `CHK(r, 2'h0)
    if (a == 4'h0) ctrl0_m = v[23] ? int'(v & 32'hFFBF_FFFF) : 0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    axi_host_i.rd(a, d, r);
    `CHK(r, 2'h0)
    `CHK(d, e)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic chk_out();
    `CHK(out_enable, exp_oe())
    `CHK(charge_pump_en, ctrl0_m[23])
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(32'h035b_b4fd));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK(out_enable, 6'h00)
    for (int i = 0; i < 4; i++) rchk(4'(i * 4), 32'(i >= 2));
    axi_host_i.rd(4'h2, d, r);
    `CHK({r, d}, 34'h0_0000_0000)
    // active, all outputs on, then bridge a to its low side and back
    wr(4'h0, 32'h0084_007E);
    idle(140);
    chk_out();
    `CHK(high_drive, 6'h3F)
    wr(4'h0, 32'h0084_00FE);
    idle(4);
    `CHK(low_drive[0], 1'b0)
    idle(140);
    `CHK(low_drive[0], 1'b1)
    wr(4'h0, 32'h0084_007E);
    idle(140);
    // every monitor select code, ending on code 1
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, (ctrl0_m & 32'hFFF3_FFFF) | 32'(((i + 2) % 4) << 18));
      idle(2);
      `CHK(monitor_select, 2'((i + 2) % 4))
    end
    // modulation on high_side_a and high_side_b
    wr(4'h4, 32'h0000_0018);
    idle(2);
    `CHK(pin_b_oe, 1'b0)
    repeat (8) begin
      mod_a <= 1'($urandom);
      pwm_b <= 1'($urandom);
      idle(4);
      `CHK(high_drive[3], mod_a)
      `CHK(high_drive[4], pwm_b)
      `CHK(high_drive[5], 1'b1)
    end
    wr(4'h4, 32'h0000_0000);
    // short undervoltage is filtered out
    raw_supply_uv <= 1'b1;
    idle(5);
    raw_supply_uv <= 1'b0;
    idle(10);
    rchk(4'h8, st_exp(st0_m));
    // overvoltage with automatic, then with disabled recovery
    for (int k = 0; k < 2; k++) begin
      wr(4'h0, ctrl0_m | 32'h0040_0000 | (32'(k) << 20));
      st0_m = 0;
      off_m = 1;
      raw_supply_ov <= 1'b1;
      idle(20);
      chk_out();
      raw_supply_ov <= 1'b0;
      idle(4);
      chk_out();
      off_m = k;
      st0_m = 32'h0000_0100;
      idle(160);
      chk_out();
      rchk(4'h8, st_exp(st0_m));
    end
    wr(4'h0, ctrl0_m | 32'h0040_0000);
    st0_m = 0;
    off_m = 0;
    idle(140);
    chk_out();
    // over-current on high_side_c held off until cleared
    raw_over_current <= 6'h20;
    idle(20);
    raw_over_current <= 6'h00;
    oc_m = 32;
    st0_m = 32'h0000_0040;
    idle(160);
    chk_out();
    rchk(4'h8, st_exp(st0_m));
    wr(4'h0, ctrl0_m | 32'h0040_0000);
    oc_m = 0;
    st0_m = 0;
    idle(140);
    chk_out();
    // over-current on high_side_a with automatic recovery
    wr(4'h4, 32'h0000_1200);
    raw_over_current <= 6'h08;
    idle(14);
    `CHK(out_enable[3], 1'b0)
    raw_over_current <= 6'h00;
    idle(30);
    `CHK(out_enable[3], 1'b0)
    idle(30);
    `CHK(out_enable[3], 1'b1)
    wr(4'h0, ctrl0_m | 32'h0040_0000);
    wr(4'h4, 32'h0000_0000);
    // thermal shutdown, clear refused while hot
    raw_thermal_sd <= 1'b1;
    idle(20);
    off_m = 1;
    st1_m = 32'h0000_4000;
    chk_out();
    wr(4'h0, ctrl0_m | 32'h0040_0000);
    rchk(4'hC, st_exp(st1_m));
    raw_thermal_sd <= 1'b0;
    idle(2);
    wr(4'h0, ctrl0_m | 32'h0040_0000);
    off_m = 0;
    st1_m = 0;
    idle(140);
    chk_out();
    // warning and open load only report
    raw_temp_warn <= 1'b1;
    raw_open_load <= 6'h08;
    idle(60);
    st1_m = 32'h0000_8800;
    chk_out();
    rchk(4'hC, st_exp(st1_m));
    raw_temp_warn <= 1'b0;
    raw_open_load <= 6'h00;
    // standby clears everything
    wr(4'h0, 32'h0000_0000);
    st1_m = 0;
    idle(3);
    chk_out();
    rchk(4'hC, st_exp(0));
    complete_run();
  end
endmodule
`default_nettype wire
